/* File: gpio_cfg_pkg.sv */
package gpio_cfg_pkg;
   // Port value register byte addresses
   localparam logic [7:0] port0_value_off      = 8'h80;
   localparam logic [7:0] port1_value_off      = 8'h90;
   localparam logic [7:0] port2_value_off      = 8'ha0;
   localparam logic [7:0] port3_value_off      = 8'hb0;
   // Configuration register byte addresses and register reset values
   localparam logic [7:0] port2_pin_config_off = 8'hc0;
   localparam logic [7:0] port3_pin_config_off = 8'hc4;
   localparam logic [7:0] port_value_rst       = 8'hff;
   localparam logic [2:0] out_cfg_rst          = 3'h0;
   localparam logic [1:0] in_cfg_rst           = 2'h0;
   // Configuration write fields
   localparam int cfg_field_msb = 7;
   localparam int cfg_field_lsb = 5;
   localparam int dir_bit       = 4;
   localparam int latch_bit     = 3;
   localparam int index_msb     = 2;
   // Input mode encodings
   localparam logic [1:0] in_no_pull   = 2'h0;
   localparam logic [1:0] in_pull_down = 2'h1;
   localparam logic [1:0] in_pull_up   = 2'h2;
   localparam logic [1:0] in_buf_off   = 2'h3;
endpackage

/* File: gpio_pin_config_port.sv */
`timescale 1ns/1ps
module gpio_pin_config_port
   import gpio_cfg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic [31:0] pin_in,
   output logic [31:0]      pin_out,
   output logic [31:0]      pin_oe,
   output logic [15:0]      pull_up_en,
   output logic [15:0]      pull_down_en,
   output logic [15:0]      in_buf_en
);

   typedef struct packed {
      logic [3:0][7:0]  port_latch;
      logic [1:0][7:0]  is_input;
      logic [1:0][7:0][2:0] out_cfg;
      logic [1:0][7:0][1:0] in_cfg;
      logic [1:0][2:0]  rd_index;
      logic [1:0]       rd_dir;
      logic [31:0]      sync1;
      logic [31:0]      sync2;
      logic             ack;
      logic [31:0]      rdata;
      logic [31:0]      oe;
      logic [15:0]      pu;
      logic [15:0]      pd;
      logic [15:0]      ibuf;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Pin index decode to one-hot pin select
   function automatic logic [7:0] pin_select(input logic [2:0] idx);
      pin_select = 8'h01 << idx;
   endfunction

   function automatic logic [7:0] value_read(input logic [7:0] lat, input logic [7:0] lvl,
                                             input logic [7:0] inp);
      value_read = (lvl & inp) | (lat & ~inp);
   endfunction

   logic [31:0] rd_mux;
   logic        req;
   logic [1:0]  cfg_sel;
   logic        cfg_hit;

   always_comb
   begin
      st_nxt = st_r;
      req = (read | write) & ~st_r.ack;
      cfg_hit = (address == port2_pin_config_off) || (address == port3_pin_config_off);
      cfg_sel = (address == port3_pin_config_off) ? 2'h1 : 2'h0;
      rd_mux = 32'h0;
      st_nxt.sync1 = pin_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.ack = req;
      case (address)
         port0_value_off: rd_mux = {24'h0, st_r.port_latch[0]};
         port1_value_off: rd_mux = {24'h0, st_r.port_latch[1]};
         port2_value_off: rd_mux = {24'h0, value_read(st_r.port_latch[2], st_r.sync2[23:16],
                                                     st_r.is_input[0])};
         port3_value_off: rd_mux = {24'h0, value_read(st_r.port_latch[3], st_r.sync2[31:24],
                                                     st_r.is_input[1])};
         default: rd_mux = 32'h0;
      endcase
      if (address == port0_value_off)
         rd_mux = {24'h0, st_r.sync2[7:0]};
      if (address == port1_value_off)
         rd_mux = {24'h0, st_r.sync2[15:8]};
      if (cfg_hit)
      begin
         if (st_r.rd_dir[cfg_sel[0]])
            rd_mux = {24'h0, 1'b0, st_r.in_cfg[cfg_sel[0]][st_r.rd_index[cfg_sel[0]]], 5'h0};
         else
            rd_mux = {24'h0, st_r.out_cfg[cfg_sel[0]][st_r.rd_index[cfg_sel[0]]], 5'h0};
      end
      st_nxt.rdata = (req & read) ? rd_mux : 32'h0;
      if (req & write & byteenable[0])
      begin
         case (address)
            port0_value_off: st_nxt.port_latch[0] = writedata[7:0];
            port1_value_off: st_nxt.port_latch[1] = writedata[7:0];
            port2_value_off: st_nxt.port_latch[2] = writedata[7:0];
            port3_value_off: st_nxt.port_latch[3] = writedata[7:0];
            default: ;
         endcase
         if (cfg_hit)
         begin
            if (writedata[latch_bit])
            begin
               st_nxt.rd_index[cfg_sel[0]] = writedata[index_msb:0];
               st_nxt.rd_dir[cfg_sel[0]] = writedata[dir_bit];
            end
            else if (writedata[dir_bit])
            begin
               st_nxt.in_cfg[cfg_sel[0]][writedata[index_msb:0]] = writedata[6:5];
               st_nxt.is_input[cfg_sel[0]] = st_r.is_input[cfg_sel[0]]
                                             | pin_select(writedata[index_msb:0]);
            end
            else
            begin
               st_nxt.out_cfg[cfg_sel[0]][writedata[index_msb:0]] =
                  writedata[cfg_field_msb:cfg_field_lsb];
               st_nxt.is_input[cfg_sel[0]] = st_r.is_input[cfg_sel[0]]
                                             & ~pin_select(writedata[index_msb:0]);
            end
         end
      end
      for (int p = 0; p < 2; p++)
      begin
         for (int b = 0; b < 8; b++)
         begin
            st_nxt.pu[p*8+b] = st_nxt.in_cfg[p][b] == in_pull_up;
            st_nxt.pd[p*8+b] = st_nxt.in_cfg[p][b] == in_pull_down;
            st_nxt.ibuf[p*8+b] = st_nxt.in_cfg[p][b] != in_buf_off;
         end
      end
      st_nxt.oe = {~st_nxt.is_input[1], ~st_nxt.is_input[0], 16'hffff};
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
         st_r.port_latch <= {4{port_value_rst}};
         // Ports 2/3 start as inputs, matching the undriven reset enables
         st_r.is_input <= '1;
         st_r.oe <= 32'h0000ffff;
         st_r.ibuf <= 16'hffff;
      end
      else
         st_r <= st_nxt;
   end

   assign readdata = st_r.rdata;
   assign waitrequest = ~st_r.ack;
   assign pin_out = {st_r.port_latch[3], st_r.port_latch[2], st_r.port_latch[1],
                     st_r.port_latch[0]};
   assign pin_oe = st_r.oe;
   assign pull_up_en = st_r.pu;
   assign pull_down_en = st_r.pd;
   assign in_buf_en = st_r.ibuf;
endmodule

/* File: gpio_pin_config_port_chk.sv */
`timescale 1ns/1ps
module gpio_pin_config_port_chk
   import gpio_cfg_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [15:0] pull_up_en,
   input wire logic [15:0] pull_down_en,
   input wire logic [15:0] in_buf_en
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire ack_w = write && !waitrequest && byteenable[0];
   wire cfg2  = ack_w && address == port2_pin_config_off && !writedata[latch_bit];
   AST_ACK: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not acknowledged");
   AST_ONE: assert property (!waitrequest |=> waitrequest) else $error("ack too long");
   AST_VAL: assert property (ack_w && address == port2_value_off
      |=> pin_out[23:16] == $past(writedata[7:0])) else $error("latch not written");
   AST_PDN: assert property (cfg2 && writedata[dir_bit] |=>
      pull_down_en[$past(writedata[2:0])] == ($past(writedata[6:5]) == in_pull_down))
      else $error("pull-down wrong");
   AST_BUF: assert property (cfg2 && writedata[dir_bit] |=>
      in_buf_en[$past(writedata[2:0])] == ($past(writedata[6:5]) != in_buf_off))
      else $error("input buffer wrong");
   AST_OE: assert property (cfg2 |=> pin_oe[16 + $past(writedata[2:0])] ==
      !$past(writedata[dir_bit])) else $error("direction wrong");
   AST_HOLD: assert property (ack_w && writedata[latch_bit] && address[7:4] == 4'hc
      |-> $stable({pin_oe, pull_up_en, pull_down_en, in_buf_en})) else $error("config changed");
   AST_P01: assert property (pin_oe[15:0] == 16'hffff) else $error("port 0/1 not driven");
   cover property (cfg2 && writedata[dir_bit]);
   cover property (ack_w && writedata[latch_bit]);
   cover property (read && !waitrequest && address == port3_pin_config_off);
endmodule
bind gpio_pin_config_port gpio_pin_config_port_chk chk (.mclk, .rstn, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .pin_in, .pin_out, .pin_oe, .pull_up_en,
   .pull_down_en, .in_buf_en);

/* File: gpio_pin_config_port_bench.sv */
`timescale 1ns/1ps
module gpio_pin_config_port_bench
   import gpio_cfg_pkg::*;
;
   logic        mclk = 0, rstn = 0, read = 0, write = 0;
   logic [7:0]  address = 8'h00;
   logic [3:0]  byteenable = 4'h1;
   logic [31:0] writedata = 32'h0, q, pin_in = 32'h5a3c96e1;
   logic [31:0] readdata, pin_out, pin_oe;
   logic        waitrequest;
   logic [15:0] pull_up_en, pull_down_en, in_buf_en;
   int          errors = 0, comparisons = 0;
   gpio_pin_config_port dut (.mclk, .rstn, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .in_buf_en);
   initial forever #4 mclk = ~mclk;
   task automatic conclude;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low, released after that edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge mclk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      byteenable <= be;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, 4'h1);
      chk(q, exp);
   endtask
   initial
   begin
      repeat (2000) @(posedge mclk);
      errors++;
      conclude();
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      chk(pin_out, 32'hffffffff);
      // Let the pin synchroniser fill before the first level read
      repeat (2) @(posedge mclk);
      for (int p = 0; p < 4; p++) rd(8'h80 + 8'(p * 16), {24'h0, pin_in[8 * p +: 8]});
      wr(port0_value_off, 32'h12);
      acc(1'b1, port1_value_off, 32'h34, 4'h0);
      @(negedge mclk);
      chk(pin_out, 32'hffffff12);
      for (int i = 0; i < 8; i++)
      begin
         logic [1:0] m;
         m = 2'(i);
         wr(port2_pin_config_off, {24'h0, 1'b0, m, 2'b10, 3'(i)});
         wr(port2_pin_config_off, {24'h0, 5'h0f, 3'(i)});
         @(negedge mclk);
         chk({pull_up_en[i], pull_down_en[i], in_buf_en[i], pin_oe[16 + i]},
            {m == in_pull_up, m == in_pull_down, m != in_buf_off, 1'b0});
         rd(port2_pin_config_off, {25'h0, m, 5'h0});
      end
      wr(port3_pin_config_off, 32'ha2);
      wr(port3_pin_config_off, 32'h0a);
      rd(port3_pin_config_off, 32'ha0);
      wr(port3_value_off, 32'h04);
      rd(port3_value_off, {24'h0, pin_in[31:24] | 8'h04});
      rd(8'h84, 32'h0);
      conclude();
   end
endmodule
